// [verilog/orm_pkg.sv]
// constants for the operand register merge and complement block
package orm_pkg;
    localparam int WORD_W = 60;
    localparam int NUM_REGS = 8;
    localparam int SEL_W = 3;
    localparam int LOW_W = 24;
    localparam int SIGN_BIT = 59;
    localparam int FANOUT_DEF = 4;
    // complement groups: bits 0-47, 48-57, 58-59
    localparam int GRP_A_LO = 0;
    localparam int GRP_A_HI = 47;
    localparam int GRP_B_LO = 48;
    localparam int GRP_B_HI = 57;
    localparam int GRP_C_LO = 58;
    localparam int GRP_C_HI = 59;
    // special-case words
    localparam logic [59:0] WORD_OVF_POS = 60'h7ff000000000000;
    localparam logic [59:0] WORD_OVF_NEG = 60'h800000000000000;
    localparam logic [59:0] WORD_UNDERFLOW = 60'h000000000000000;
    localparam logic [59:0] WORD_INDEF = 60'h3ff000000000000;
    localparam logic [59:0] WORD_IDLE = 60'hfffffffffffffff;
    // apb map
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_RDSEL = 8'h00;
    localparam logic [7:0] OFF_RDLO = 8'h04;
    localparam logic [7:0] OFF_RDHI = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [2:0] RDSEL_RESET = 3'h0;
    // status fields
    localparam int ST_LASTSEL_LO = 0;
    localparam int ST_ENTERED = 3;
    localparam int ST_OVF = 4;
    localparam int ST_UNF = 5;
    localparam int ST_INDEF = 6;
endpackage

// [verilog/orm_merge_complement.sv]
// operand register bank with write merge/complement and read network
// Notes on behaviour
// - unit special cases form overflow, clearing bit 59
// - translator forms complement controls from unit info
// - two static merges around complement control
// - merged word loads selected register on enter
// - invert multiply/divide output when coefficient negative
// - invert normalize/shift output when result positive
// - memory delivery turns idle ones to zeros
// - positive overflow inverts bits 0-47
// - negative overflow inverts bits 0-59
// - underflow inverts whole word to zero
// - indefinite inverts bits 0-47, 58, 59
// - decode i, j, k; route three operands
// - fan out sign bit of j, k
// - m bit 1 picks k or i for shift
// - register zero low 24 bits always out
// - eight 60-bit registers, one loaded per cycle
//
// Chosen here: the APB interface to the registers and the register offsets.
module orm_merge_complement #(
    parameter int SIGN_FANOUT = orm_pkg::FANOUT_DEF
) (
    input wire logic sys_clk,
    input wire logic rst,
    // first group: multiply, divide, shift, normalize
    input wire logic [59:0] mulResult,
    input wire logic [59:0] divResult,
    input wire logic [59:0] shiftResult,
    input wire logic [59:0] normResult,
    // second group: remaining units and memory controller
    input wire logic [59:0] faddResult,
    input wire logic [59:0] longAddResult,
    input wire logic [59:0] boolResult,
    input wire logic [59:0] popResult,
    input wire logic [59:0] incrResult,
    input wire logic [59:0] memoryControllerData,
    // special-case and sign treatment
    input wire logic faddOverflow,
    input wire logic mulOverflow,
    input wire logic divOverflow,
    input wire logic overflowNegative,
    input wire logic underflowCase,
    input wire logic indefiniteCase,
    input wire logic mulDivNegative,
    input wire logic normShiftPositive,
    input wire logic memoryDeliver,
    // write select
    input wire logic enterReg,
    input wire logic [2:0] regSelect,
    // designators of the current instruction word
    input wire logic [2:0] desigI,
    input wire logic [2:0] desigJ,
    input wire logic [2:0] desigK,
    input wire logic mBit1,
    // read network outputs
    output logic [59:0] resultOperand,
    output logic [59:0] firstSource,
    output logic [59:0] secondSource,
    output logic [59:0] shiftOperand,
    output logic [SIGN_FANOUT-1:0] firstSignFan,
    output logic [SIGN_FANOUT-1:0] secondSignFan,
    output logic [23:0] regZeroLow,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    if (SIGN_FANOUT < 1) begin : g_chk
        $error("SIGN_FANOUT must be at least one");
    end

    logic [59:0] opReg_reg [orm_pkg::NUM_REGS];
    logic [59:0] group1Merge;
    logic [59:0] group1Forced;
    logic [59:0] complemented;
    logic [59:0] finalWord;
    logic [59:0] invMask;
    logic [59:0] memGated;
    logic overflowAny;
    logic cmpLow;
    logic cmpMid;
    logic cmpTop;

    // overflow merged from the three floating units
    assign overflowAny = faddOverflow | mulOverflow | divOverflow;

    // idle units send ones, so a wired-and merge needs no select
    assign group1Merge = mulResult & divResult & shiftResult & normResult;

    // first step of the overflow exponent pattern
    always_comb begin
        group1Forced = group1Merge;
        group1Forced[orm_pkg::SIGN_BIT] =
            group1Merge[orm_pkg::SIGN_BIT] & ~overflowAny;
    end

    // translator: memory delivery wins, then special cases, then sign
    always_comb begin
        cmpLow = 1'b0;
        cmpMid = 1'b0;
        cmpTop = 1'b0;
        if (memoryDeliver) begin
            cmpLow = 1'b1;
            cmpMid = 1'b1;
            cmpTop = 1'b1;
        end else if (overflowAny) begin
            cmpLow = 1'b1;
            cmpMid = overflowNegative;
            cmpTop = overflowNegative;
        end else if (underflowCase) begin
            cmpLow = 1'b1;
            cmpMid = 1'b1;
            cmpTop = 1'b1;
        end else if (indefiniteCase) begin
            cmpLow = 1'b1;
            cmpTop = 1'b1;
        end else if (mulDivNegative || normShiftPositive) begin
            // sign complement is all three groups together
            cmpLow = 1'b1;
            cmpMid = 1'b1;
            cmpTop = 1'b1;
        end
    end

    // each group inverts its own slice only
    always_comb begin
        invMask = '0;
        invMask[orm_pkg::GRP_A_HI:orm_pkg::GRP_A_LO] = {48{cmpLow}};
        invMask[orm_pkg::GRP_B_HI:orm_pkg::GRP_B_LO] = {10{cmpMid}};
        invMask[orm_pkg::GRP_C_HI:orm_pkg::GRP_C_LO] = {2{cmpTop}};
    end

    assign complemented = group1Forced ^ invMask;

    // memory idles at ones as well, so it joins only while delivering;
    // the zeroed first group then lets its word through unaltered
    assign memGated = memoryDeliver ? memoryControllerData : '0;

    // second static merge with the rest and memory data
    assign finalWord = (complemented & faddResult & longAddResult
        & boolResult & popResult & incrResult) | memGated;

    // one register loads the broadcast word per period
    // with enter low every register holds
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int r = 0; r < orm_pkg::NUM_REGS; r++) begin
                opReg_reg[r] <= '0;
            end
        end else if (enterReg) begin
            opReg_reg[regSelect] <= finalWord;
        end
    end

    // read network, registered so outputs come from flip-flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            resultOperand <= '0;
            firstSource <= '0;
            secondSource <= '0;
        end else begin
            resultOperand <= opReg_reg[desigI];
            firstSource <= opReg_reg[desigJ];
            secondSource <= opReg_reg[desigK];
        end
    end

    // sign fanout so heavy loads do not share one net
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            firstSignFan <= '0;
            secondSignFan <= '0;
        end else begin
            firstSignFan <=
                {SIGN_FANOUT{opReg_reg[desigJ][orm_pkg::SIGN_BIT]}};
            secondSignFan <=
                {SIGN_FANOUT{opReg_reg[desigK][orm_pkg::SIGN_BIT]}};
        end
    end

    // shift operand: nominal shifts use k, constant shifts use i
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shiftOperand <= '0;
        end else if (mBit1) begin
            shiftOperand <= opReg_reg[desigK];
        end else begin
            shiftOperand <= opReg_reg[desigI];
        end
    end

    // register zero low bits go out with no condition
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regZeroLow <= '0;
        end else begin
            regZeroLow <= opReg_reg[0][orm_pkg::LOW_W-1:0];
        end
    end

    // ---- apb slave: readback select and status ----
    logic [2:0] readSel_reg;
    logic [2:0] lastSel_reg;
    logic entered_reg;
    logic sawOvf_reg;
    logic sawUnf_reg;
    logic sawIndef_reg;
    logic setupPhase;
    logic accessDone;
    logic [31:0] readValue;
    logic addrOk;

    // one wait-free access: pready rises for the access cycle only
    assign setupPhase = psel & ~penable & ~pready;
    assign accessDone = psel & penable & pready;

    always_comb begin
        readValue = '0;
        addrOk = 1'b1;
        case (paddr)
            orm_pkg::OFF_RDSEL: readValue[2:0] = readSel_reg;
            orm_pkg::OFF_RDLO: readValue = opReg_reg[readSel_reg][31:0];
            orm_pkg::OFF_RDHI:
                readValue[27:0] = opReg_reg[readSel_reg][59:32];
            orm_pkg::OFF_STATUS: begin
                readValue[orm_pkg::ST_LASTSEL_LO +: 3] = lastSel_reg;
                readValue[orm_pkg::ST_ENTERED] = entered_reg;
                readValue[orm_pkg::ST_OVF] = sawOvf_reg;
                readValue[orm_pkg::ST_UNF] = sawUnf_reg;
                readValue[orm_pkg::ST_INDEF] = sawIndef_reg;
            end
            default: addrOk = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setupPhase;
            pslverr <= setupPhase & ~addrOk;
            if (setupPhase && !pwrite) begin
                prdata <= readValue;
            end
        end
    end

    // readback select steers which register software sees
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            readSel_reg <= orm_pkg::RDSEL_RESET;
        end else if (accessDone && pwrite && paddr == orm_pkg::OFF_RDSEL) begin
            readSel_reg <= pwdata[2:0];
        end
    end

    // sticky status; a new event in the clearing write wins
    logic statusClear;
    assign statusClear = accessDone & pwrite & (paddr == orm_pkg::OFF_STATUS);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lastSel_reg <= '0;
            entered_reg <= 1'b0;
            sawOvf_reg <= 1'b0;
            sawUnf_reg <= 1'b0;
            sawIndef_reg <= 1'b0;
        end else begin
            if (enterReg) begin
                lastSel_reg <= regSelect;
            end
            entered_reg <= enterReg | (entered_reg & ~statusClear);
            sawOvf_reg <= (enterReg & overflowAny & ~memoryDeliver)
                | (sawOvf_reg & ~statusClear);
            sawUnf_reg <= (enterReg & underflowCase & ~memoryDeliver)
                | (sawUnf_reg & ~statusClear);
            sawIndef_reg <= (enterReg & indefiniteCase & ~memoryDeliver)
                | (sawIndef_reg & ~statusClear);
        end
    end

    // ---- checks ----
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic allOnesIn;
    assign allOnesIn = (group1Merge == orm_pkg::WORD_IDLE)
        && ((faddResult & longAddResult & boolResult & popResult
        & incrResult & memoryControllerData) == orm_pkg::WORD_IDLE);

    sequence s_enter;
        enterReg;
    endsequence

    ovf_pos_word_a: assert property (
        allOnesIn && overflowAny && !overflowNegative && !memoryDeliver
        |-> finalWord == orm_pkg::WORD_OVF_POS)
        else $error("positive overflow word wrong");

    ovf_neg_word_a: assert property (
        allOnesIn && overflowAny && overflowNegative && !memoryDeliver
        |-> finalWord == orm_pkg::WORD_OVF_NEG)
        else $error("negative overflow word wrong");

    underflow_word_a: assert property (
        allOnesIn && !overflowAny && underflowCase && !memoryDeliver
        |-> finalWord == orm_pkg::WORD_UNDERFLOW)
        else $error("underflow word wrong");

    indef_word_a: assert property (
        allOnesIn && !overflowAny && !underflowCase && indefiniteCase
        && !memoryDeliver |-> finalWord == orm_pkg::WORD_INDEF)
        else $error("indefinite word wrong");

    mem_pass_a: assert property (
        memoryDeliver && group1Merge == orm_pkg::WORD_IDLE
        && (faddResult & longAddResult & boolResult & popResult
        & incrResult) == orm_pkg::WORD_IDLE
        |-> finalWord == memoryControllerData)
        else $error("memory data altered by merge");

    sign_invert_a: assert property (
        mulDivNegative && !memoryDeliver && !overflowAny && !underflowCase
        && !indefiniteCase |-> complemented == ~group1Merge)
        else $error("negative result not inverted");

    shift_sign_a: assert property (
        normShiftPositive && !memoryDeliver && !overflowAny
        && !underflowCase && !indefiniteCase |-> complemented == ~group1Merge)
        else $error("positive shift result not inverted");

    enter_load_a: assert property (
        s_enter ##1 1'b1 |->
        opReg_reg[$past(regSelect)] == $past(finalWord))
        else $error("selected register did not load");

    hold_idle_a: assert property (
        !enterReg |=> opReg_reg[0] == $past(opReg_reg[0])
        && opReg_reg[7] == $past(opReg_reg[7]))
        else $error("register changed without enter");

    shift_pick_a: assert property (
        ##1 shiftOperand == ($past(mBit1) ? secondSource : resultOperand))
        else $error("shift operand from wrong register");

    fan_sign_a: assert property (
        firstSignFan == {SIGN_FANOUT{firstSource[orm_pkg::SIGN_BIT]}}
        && secondSignFan == {SIGN_FANOUT{secondSource[orm_pkg::SIGN_BIT]}})
        else $error("sign fanout mismatch");

    low_bits_a: assert property (
        ##1 regZeroLow == $past(opReg_reg[0][orm_pkg::LOW_W-1:0]))
        else $error("register zero low bits stale");

    apb_ready_a: assert property (
        psel && !penable && !pready |=> pready ##1 !pready)
        else $error("pready not one cycle");
endmodule

// [tb/orm_unit_model.sv]
// far-side model: nine functional units and the memory controller
module orm_unit_model (
    input wire logic [3:0] unitSel,
    input wire logic unitValid,
    input wire logic [59:0] unitData,
    output logic [59:0] mulResult,
    output logic [59:0] divResult,
    output logic [59:0] shiftResult,
    output logic [59:0] normResult,
    output logic [59:0] faddResult,
    output logic [59:0] longAddResult,
    output logic [59:0] boolResult,
    output logic [59:0] popResult,
    output logic [59:0] incrResult,
    output logic [59:0] memoryControllerData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [59:0] res [10];
    // one index selects the only source, so two can never deliver at once
    always_comb begin
        for (int u = 0; u < 10; u++) begin
            res[u] = (unitValid && unitSel == 4'(u)) ? unitData
                : orm_pkg::WORD_IDLE;
        end
    end
    assign mulResult = res[0];
    assign divResult = res[1];
    assign shiftResult = res[2];
    assign normResult = res[3];
    assign faddResult = res[4];
    assign longAddResult = res[5];
    assign boolResult = res[6];
    assign popResult = res[7];
    assign incrResult = res[8];
    assign memoryControllerData = res[9];
endmodule

// [tb/orm_merge_complement_test.sv]
// self-checking testbench of the operand register merge block
module orm_merge_complement_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FAN = 3;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] unitSel = 4'h0;
    logic unitValid = 1'b0;
    logic [59:0] unitData = 60'h0;
    logic faddOverflow = 1'b0, mulOverflow = 1'b0, divOverflow = 1'b0;
    logic overflowNegative = 1'b0, underflowCase = 1'b0;
    logic indefiniteCase = 1'b0, mulDivNegative = 1'b0;
    logic normShiftPositive = 1'b0, memoryDeliver = 1'b0;
    logic enterReg = 1'b0, mBit1 = 1'b0;
    logic [2:0] regSelect = 3'h0, desigI = 3'h0;
    logic [2:0] desigJ = 3'h0, desigK = 3'h0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [59:0] mulResult, divResult, shiftResult, normResult;
    logic [59:0] faddResult, longAddResult, boolResult, popResult;
    logic [59:0] incrResult, memoryControllerData;
    logic [59:0] resultOperand, firstSource, secondSource, shiftOperand;
    logic [FAN-1:0] firstSignFan, secondSignFan;
    logic [23:0] regZeroLow;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [59:0] regs [8] = '{default: 60'h0};
    logic [31:0] lfsrState = 32'h38;
    int failures = 0;
    int check_count = 0;
    int spU [5] = '{4, 0, 1, 0, 1};
    // flag bits: 0 sign, 1 fadd, 2 mul, 3 div, 4 negative, 5 unf, 6 indef
    logic [6:0] spF [5] = '{7'h02, 7'h04, 7'h18, 7'h20, 7'h40};
    logic [59:0] spW [5] = '{orm_pkg::WORD_OVF_POS, orm_pkg::WORD_OVF_POS,
        orm_pkg::WORD_OVF_NEG, orm_pkg::WORD_UNDERFLOW, orm_pkg::WORD_INDEF};
    int u;
    logic [59:0] d;
    logic [2:0] n;
    logic nb, e;
    logic [31:0] v;

    always #20 sys_clk = ~sys_clk;

    orm_unit_model far (.unitSel, .unitValid, .unitData, .mulResult,
        .divResult, .shiftResult, .normResult, .faddResult, .longAddResult,
        .boolResult, .popResult, .incrResult, .memoryControllerData);

    orm_merge_complement #(.SIGN_FANOUT(FAN)) dut (.sys_clk, .rst,
        .mulResult, .divResult, .shiftResult, .normResult, .faddResult,
        .longAddResult, .boolResult, .popResult, .incrResult,
        .memoryControllerData, .faddOverflow, .mulOverflow, .divOverflow,
        .overflowNegative, .underflowCase, .indefiniteCase, .mulDivNegative,
        .normShiftPositive, .memoryDeliver, .enterReg, .regSelect, .desigI,
        .desigJ, .desigK, .mBit1, .resultOperand, .firstSource,
        .secondSource, .shiftOperand, .firstSignFan, .secondSignFan,
        .regZeroLow, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);

    function automatic logic [31:0] rnd();
        lfsrState = {lfsrState[30:0],
            lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
        return lfsrState;
    endfunction

    // idle units show ones and merge by and; memory joins only on delivery
    function automatic logic [59:0] exp_word(input int k,
        input logic [59:0] x, input logic neg);
        logic [59:0] g1, g2, mem;
        g1 = k < 4 ? x : orm_pkg::WORD_IDLE;
        g2 = (k >= 4 && k < 9) ? x : orm_pkg::WORD_IDLE;
        mem = k == 9 ? x : 60'h0;
        if (k == 9 || neg) begin
            g1 = ~g1;
        end
        return (g1 & g2) | mem;
    endfunction

    task check60(input logic [59:0] x, input logic [59:0] g);
        check_count++;
        if (g !== x) begin
            failures++;
            $display("BAD t=%0t exp=%h got=%h", $time, x, g);
        end
    endtask

    task check32(input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            failures++;
            $display("BAD t=%0t exp=%h got=%h", $time, x, g);
        end
    endtask

    task put(input int k, input logic [59:0] x, input logic [2:0] r,
        input logic [6:0] f);
        @(posedge sys_clk);
        unitSel <= 4'(k);
        unitValid <= 1'b1;
        unitData <= x;
        enterReg <= 1'b1;
        regSelect <= r;
        memoryDeliver <= (k == 9);
        mulDivNegative <= f[0] && k < 2;
        normShiftPositive <= f[0] && k >= 2 && k < 4;
        {indefiniteCase, underflowCase, overflowNegative, divOverflow,
            mulOverflow, faddOverflow} <= f[6:1];
    endtask

    task idle();
        @(posedge sys_clk);
        {unitValid, enterReg, memoryDeliver, mulDivNegative,
            normShiftPositive, indefiniteCase, underflowCase,
            overflowNegative, divOverflow, mulOverflow, faddOverflow} <= '0;
    endtask

    task rd(input logic [2:0] r);
        logic [2:0] j, k;
        logic m;
        j = r + 3'h1;
        k = r + 3'h2;
        m = 1'(rnd());
        @(posedge sys_clk);
        desigI <= r;
        desigJ <= j;
        desigK <= k;
        mBit1 <= m;
        @(posedge sys_clk);
        #1;
        check60(regs[r], resultOperand);
        check60(regs[j], firstSource);
        check60(regs[k], secondSource);
        check60(m ? regs[k] : regs[r], shiftOperand);
        check60(60'({FAN{regs[j][59]}}), 60'(firstSignFan));
        check60(60'({FAN{regs[k][59]}}), 60'(secondSignFan));
        check60(60'(regs[0][23:0]), 60'(regZeroLow));
    endtask

    task apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
        output logic [31:0] r, output logic er);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task results();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        results();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        check60(60'h0, 60'(regZeroLow));
        apb(orm_pkg::OFF_RDSEL, 1'b0, 32'h0, v, e);
        check32(32'(orm_pkg::RDSEL_RESET), v);
        for (int c = 0; c < 5; c++) begin
            put(spU[c], orm_pkg::WORD_IDLE, 3'(c + 3), spF[c]);
            idle();
            regs[c + 3] = spW[c];
            rd(3'(c + 3));
        end
        apb(orm_pkg::OFF_STATUS, 1'b0, 32'h0, v, e);
        check32(32'h77, v & 32'h77);
        apb(orm_pkg::OFF_STATUS, 1'b1, 32'h0, v, e);
        apb(orm_pkg::OFF_STATUS, 1'b0, 32'h0, v, e);
        check32(32'h0, v & 32'h70);
        for (int i = 0; i < 40; i++) begin
            u = i < 10 ? i : int'(rnd() % 10);
            d = 60'({rnd(), rnd()});
            n = 3'(rnd());
            nb = 1'(rnd()) && u < 4;
            put(u, d, n, {6'h0, nb});
            idle();
            regs[n] = exp_word(u, d, nb);
            rd(n);
        end
        // back-to-back enters into every register
        for (int i = 0; i < 8; i++) begin
            u = int'(rnd() % 10);
            d = 60'({rnd(), rnd()});
            put(u, d, 3'(i), 7'h0);
            regs[i] = exp_word(u, d, 1'b0);
        end
        idle();
        for (int i = 0; i < 8; i++) begin
            rd(3'(i));
        end
        apb(orm_pkg::OFF_RDSEL, 1'b1, 32'h5, v, e);
        apb(orm_pkg::OFF_RDLO, 1'b0, 32'h0, v, e);
        check32(regs[5][31:0], v);
        check32(32'h0, 32'(e));
        apb(orm_pkg::OFF_RDHI, 1'b0, 32'h0, v, e);
        check32(32'(regs[5][59:32]), v);
        apb(8'h10, 1'b0, 32'h0, v, e);
        check32(32'h1, 32'(e));
        results();
    end
endmodule
